// ===== design/rsc_regs.sv
// Register bank holding reference selection and offset and gain calibration,
// plus the correction path that applies them to raw conversion results.
// Assumes an APB master on pclk and raw results synchronous to pclk.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module rsc_regs
  import rsc_pkg::*;
(
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Reference routing.
  output logic      [1:0]  pos_reference_select,
  output logic      [1:0]  neg_reference_select,
  output logic             pos_ref_supply_en,
  output logic             pos_ref_pin_zero_en,
  output logic             pos_ref_ain_zero_en,
  output logic             neg_ref_supply_en,
  output logic             neg_ref_pin_zero_en,
  output logic             neg_ref_ain_one_en,
  // Correction path.
  input  wire logic        raw_valid,
  input  wire logic [23:0] raw_data,
  output logic             cor_valid,
  output logic      [23:0] cor_data,
  output logic      [23:0] offset_correction_word,
  output logic      [23:0] gain_correction_word
);

  logic [3:0]  ref_sel_q;
  logic [7:0]  cal_q [6];
  logic        wr_en;
  logic        rd_en;
  logic [5:0]  word_idx;
  logic        addr_ok;
  logic [31:0] rdata_d;
  logic        cor_valid_q;
  logic [23:0] cor_data_q;
  logic signed [24:0] ofs_diff;
  logic signed [49:0] scaled;
  logic signed [49:0] scaled_sh;
  logic [23:0] sat_d;

  // Zero wait states keep software access simple; every access finishes in the access phase.
  assign pready  = 1'b1;
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & ~penable & ~pwrite;
  assign word_idx = paddr[7:2];
  assign addr_ok = (paddr[1:0] == 2'h0) && ({2'h0, word_idx} >= RSC_IDX_REF_SEL)
                   && ({2'h0, word_idx} <= RSC_IDX_SPARE_0B);
  assign pslverr = psel & penable & ~addr_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_sel_q <= RSC_RST_REF_SEL[3:0];
    end else if (wr_en && addr_ok && pstrb[0] && {2'h0, word_idx} == RSC_IDX_REF_SEL) begin
      ref_sel_q <= pwdata[3:0] & RSC_REF_SEL_MASK;
    end
  end

  // Calibration bytes, indexed from the low offset byte upward.
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_cal
      localparam logic [7:0] IDX = RSC_IDX_OFS_LOW + 8'(gi);
      localparam logic [7:0] RST = (gi < 3) ? RSC_RST_OFS_BYTE :
                                   (gi == 3) ? RSC_RST_GAIN_LOW :
                                   (gi == 4) ? RSC_RST_GAIN_MID : RSC_RST_GAIN_HIGH;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cal_q[gi] <= RST;
        end else if (wr_en && addr_ok && pstrb[0] && {2'h0, word_idx} == IDX) begin
          cal_q[gi] <= pwdata[7:0];
        end
      end
    end
  endgenerate

  assign offset_correction_word = {cal_q[2], cal_q[1], cal_q[0]};
  assign gain_correction_word   = {cal_q[5], cal_q[4], cal_q[3]};

  always_comb begin
    rdata_d = 32'h0;
    unique case ({2'h0, word_idx})
      RSC_IDX_REF_SEL:   rdata_d = {28'h0, ref_sel_q};
      RSC_IDX_OFS_LOW:   rdata_d = {24'h0, cal_q[0]};
      RSC_IDX_OFS_MID:   rdata_d = {24'h0, cal_q[1]};
      RSC_IDX_OFS_HIGH:  rdata_d = {24'h0, cal_q[2]};
      RSC_IDX_GAIN_LOW:  rdata_d = {24'h0, cal_q[3]};
      RSC_IDX_GAIN_MID:  rdata_d = {24'h0, cal_q[4]};
      RSC_IDX_GAIN_HIGH: rdata_d = {24'h0, cal_q[5]};
      RSC_IDX_SPARE_1S:  rdata_d = {24'h0, RSC_SPARE_1S_VAL};
      RSC_IDX_SPARE_0A:  rdata_d = {24'h0, RSC_SPARE_0_VAL};
      RSC_IDX_SPARE_0B:  rdata_d = {24'h0, RSC_SPARE_0_VAL};
      default:           rdata_d = 32'h0;
    endcase
    if (paddr[1:0] != 2'h0) begin
      rdata_d = 32'h0;
    end
  end

  // Read data is captured in the setup phase so it stands registered in the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_en) begin
      prdata <= rdata_d;
    end
  end

  assign pos_reference_select = ref_sel_q[RSC_POS_SEL_LSB +: 2];
  assign neg_reference_select = ref_sel_q[RSC_NEG_SEL_LSB +: 2];
  // Reserved code 00 opens every switch rather than guessing a route.
  assign pos_ref_supply_en   = (pos_reference_select == RSC_POS_SUPPLY);
  assign pos_ref_pin_zero_en = (pos_reference_select == RSC_POS_PIN_ZERO);
  assign pos_ref_ain_zero_en = (pos_reference_select == RSC_POS_AIN_ZERO);
  assign neg_ref_supply_en   = (neg_reference_select == RSC_NEG_SUPPLY);
  assign neg_ref_pin_zero_en = (neg_reference_select == RSC_NEG_PIN_ZERO);
  assign neg_ref_ain_one_en  = (neg_reference_select == RSC_NEG_AIN_ONE);

  // The result saturates to the 24-bit signed range since gains above unity can overflow.
  always_comb begin
    ofs_diff  = 25'($signed(raw_data)) - 25'($signed(offset_correction_word));
    scaled    = 50'(ofs_diff) * $signed({1'b0, gain_correction_word});
    scaled_sh = scaled >>> RSC_GAIN_SHIFT;
    if (scaled_sh > 50'sh7fffff) begin
      sat_d = 24'h7fffff;
    end else if (scaled_sh < -50'sh800000) begin
      sat_d = 24'h800000;
    end else begin
      sat_d = scaled_sh[23:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cor_valid_q <= 1'b0;
      cor_data_q  <= 24'h0;
    end else begin
      cor_valid_q <= raw_valid;
      if (raw_valid) begin
        cor_data_q <= sat_d;
      end
    end
  end

  assign cor_valid = cor_valid_q;
  assign cor_data  = cor_data_q;

  a_ref_reset_val: assert property (
    @(posedge pclk)
    $rose(presetn)
    |-> ref_sel_q == RSC_RST_REF_SEL[3:0])
    else $error("Reference select not at reset value.");

  a_gain_reset_val: assert property (
    @(posedge pclk)
    $rose(presetn)
    |-> gain_correction_word == RSC_GAIN_UNITY && offset_correction_word == 24'h0)
    else $error("Calibration reset values wrong.");

  a_cor_reset_idle: assert property (
    @(posedge pclk)
    $rose(presetn)
    |-> !cor_valid && cor_data == 24'h0)
    else $error("Correction output not idle after reset.");

  a_pos_supply_route: assert property (
    @(posedge pclk) disable iff (!presetn)
    pos_ref_supply_en
    == (pos_reference_select == 2'b01))
    else $error("Positive supply route wrong.");

  a_pos_pin_route: assert property (
    @(posedge pclk) disable iff (!presetn)
    pos_ref_pin_zero_en
    == (pos_reference_select == 2'b10))
    else $error("Positive pin zero route wrong.");

  a_pos_ain_route: assert property (
    @(posedge pclk) disable iff (!presetn)
    pos_ref_ain_zero_en
    == (pos_reference_select == 2'b11))
    else $error("Positive input zero route wrong.");

  a_pos_rsvd_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    pos_reference_select == 2'b00
    |-> !(pos_ref_supply_en || pos_ref_pin_zero_en || pos_ref_ain_zero_en))
    else $error("Positive reserved code closed a switch.");

  a_pos_route_one: assert property (
    @(posedge pclk) disable iff (!presetn)
    $onehot0({pos_ref_supply_en, pos_ref_pin_zero_en,
              pos_ref_ain_zero_en}))
    else $error("Positive reference route wrong.");

  a_neg_supply_route: assert property (
    @(posedge pclk) disable iff (!presetn)
    neg_ref_supply_en
    == (neg_reference_select == 2'b01))
    else $error("Negative supply route wrong.");

  a_neg_pin_route: assert property (
    @(posedge pclk) disable iff (!presetn)
    neg_ref_pin_zero_en
    == (neg_reference_select == 2'b10))
    else $error("Negative pin zero route wrong.");

  a_neg_ain_route: assert property (
    @(posedge pclk) disable iff (!presetn)
    neg_ref_ain_one_en
    == (neg_reference_select == 2'b11))
    else $error("Negative input one route wrong.");

  a_neg_rsvd_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    neg_reference_select == 2'b00
    |-> !(neg_ref_supply_en || neg_ref_pin_zero_en || neg_ref_ain_one_en))
    else $error("Negative reserved code closed a switch.");

  a_neg_route_one: assert property (
    @(posedge pclk) disable iff (!presetn)
    $onehot0({neg_ref_supply_en, neg_ref_pin_zero_en,
              neg_ref_ain_one_en}))
    else $error("Negative reference route wrong.");

  a_ref_upper_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_en && paddr == 8'h18
    |=> prdata[31:4] == 28'h0)
    else $error("Reference reserved bits read nonzero.");

  a_ref_write_lands: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && pstrb[0] && paddr == 8'h18
    |=> ref_sel_q == $past(pwdata[3:0]))
    else $error("Reference select not written.");

  a_ofs_low_lands: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && pstrb[0] && paddr == 8'h1c
    |=> offset_correction_word[7:0] == $past(pwdata[7:0]))
    else $error("Offset low byte not written.");

  a_ofs_mid_lands: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && pstrb[0] && paddr == 8'h20
    |=> offset_correction_word[15:8] == $past(pwdata[7:0]))
    else $error("Offset middle byte not written.");

  a_ofs_write_lands: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && pstrb[0] && paddr == 8'h24
    |=> offset_correction_word[23:16] == $past(pwdata[7:0]))
    else $error("Offset high byte not written.");

  a_gain_low_lands: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && pstrb[0] && paddr == 8'h28
    |=> gain_correction_word[7:0] == $past(pwdata[7:0]))
    else $error("Gain low byte not written.");

  a_gain_mid_lands: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && pstrb[0] && paddr == 8'h2c
    |=> gain_correction_word[15:8] == $past(pwdata[7:0]))
    else $error("Gain middle byte not written.");

  a_gain_high_lands: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && pstrb[0] && paddr == 8'h30
    |=> gain_correction_word[23:16] == $past(pwdata[7:0]))
    else $error("Gain high byte not written.");

  a_unity_passes: assert property (
    @(posedge pclk) disable iff (!presetn)
    raw_valid && gain_correction_word == RSC_GAIN_UNITY && offset_correction_word == 24'h0
    |=> cor_valid && cor_data == $past(raw_data))
    else $error("Unity gain changed the data.");

  a_offset_first: assert property (
    @(posedge pclk) disable iff (!presetn)
    raw_valid && gain_correction_word == RSC_GAIN_UNITY && raw_data == 24'h000064
    && offset_correction_word == 24'hfffff0 |=> cor_data == 24'h000074)
    else $error("Offset not subtracted.");

  a_half_gain: assert property (
    @(posedge pclk) disable iff (!presetn)
    raw_valid && gain_correction_word == 24'h200000 && raw_data == 24'h000064
    && offset_correction_word == 24'hfffff0 |=> cor_data == 24'h00003a)
    else $error("Gain not applied after offset.");

  a_cor_pulse: assert property (
    @(posedge pclk) disable iff (!presetn)
    raw_valid
    |=> cor_valid)
    else $error("Corrected result not flagged.");

  a_cor_only_after: assert property (
    @(posedge pclk) disable iff (!presetn)
    !raw_valid
    |=> !cor_valid)
    else $error("Corrected result flagged without input.");

  a_cor_holds: assert property (
    @(posedge pclk) disable iff (!presetn)
    !raw_valid
    |=> $stable(cor_data))
    else $error("Corrected data moved without input.");

  a_spare_reads: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_en && paddr == 8'h34
    |=> prdata == 32'h000000ff)
    else $error("Spare register 0Dh read wrong.");

  a_zero_spares: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_en && (paddr == 8'h38 || paddr == 8'h3c)
    |=> prdata == 32'h0)
    else $error("Spare zero register read nonzero.");

  a_spare_no_store: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && (paddr == 8'h34 || paddr == 8'h38 || paddr == 8'h3c)
    |=> $stable(ref_sel_q) && $stable(offset_correction_word) && $stable(gain_correction_word))
    else $error("Write to spare register changed state.");

endmodule : rsc_regs

// ===== design/rsc_pkg.sv
// Package for the reference select and calibration register bank.
// Assumes an APB slave with 32-bit data and one aligned word per register.
package rsc_pkg;

  // Printed offsets are register indices; byte address is four times the index.
  localparam logic [7:0] RSC_IDX_REF_SEL   = 8'h06;
  localparam logic [7:0] RSC_IDX_OFS_LOW   = 8'h07;
  localparam logic [7:0] RSC_IDX_OFS_MID   = 8'h08;
  localparam logic [7:0] RSC_IDX_OFS_HIGH  = 8'h09;
  localparam logic [7:0] RSC_IDX_GAIN_LOW  = 8'h0a;
  localparam logic [7:0] RSC_IDX_GAIN_MID  = 8'h0b;
  localparam logic [7:0] RSC_IDX_GAIN_HIGH = 8'h0c;
  localparam logic [7:0] RSC_IDX_SPARE_1S  = 8'h0d;
  localparam logic [7:0] RSC_IDX_SPARE_0A  = 8'h0e;
  localparam logic [7:0] RSC_IDX_SPARE_0B  = 8'h0f;

  // Reset values.
  localparam logic [7:0]  RSC_RST_REF_SEL   = 8'h05;
  localparam logic [7:0]  RSC_RST_OFS_BYTE  = 8'h00;
  localparam logic [7:0]  RSC_RST_GAIN_LOW  = 8'h00;
  localparam logic [7:0]  RSC_RST_GAIN_MID  = 8'h00;
  localparam logic [7:0]  RSC_RST_GAIN_HIGH = 8'h40;
  localparam logic [7:0]  RSC_SPARE_1S_VAL  = 8'hff;
  localparam logic [7:0]  RSC_SPARE_0_VAL   = 8'h00;

  // Field layout of the reference select register.
  localparam int          RSC_POS_SEL_LSB = 2;
  localparam int          RSC_NEG_SEL_LSB = 0;
  localparam logic [3:0]  RSC_REF_SEL_MASK = 4'hf;

  // Unity gain for the correction word and its shift.
  localparam logic [23:0] RSC_GAIN_UNITY = 24'h400000;
  localparam int          RSC_GAIN_SHIFT = 22;

  typedef enum logic [1:0] {
    RSC_POS_RSVD = 2'b00,
    RSC_POS_SUPPLY = 2'b01,
    RSC_POS_PIN_ZERO = 2'b10,
    RSC_POS_AIN_ZERO = 2'b11
  } rsc_pos_ref_t;

  typedef enum logic [1:0] {
    RSC_NEG_RSVD = 2'b00,
    RSC_NEG_SUPPLY = 2'b01,
    RSC_NEG_PIN_ZERO = 2'b10,
    RSC_NEG_AIN_ONE = 2'b11
  } rsc_neg_ref_t;

endpackage : rsc_pkg

// ===== sim/rsc_regs_tb.sv
// Self-checking bench for the reference select and calibration register bank.
// Assumes a single pclk domain and an APB slave that may insert wait states.
`timescale 1ns/1ps
module rsc_regs_tb
  import rsc_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, raw_valid;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [23:0] raw_data, cor_data, ofs_w, gain_w;
  logic [1:0]  pos_sel, neg_sel;
  logic        pready, pslverr, cor_valid, err;
  logic [5:0]  en;
  int          fail_count, compares;

  rsc_regs rsc_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pos_reference_select(pos_sel),
    .neg_reference_select(neg_sel), .pos_ref_supply_en(en[5]), .pos_ref_pin_zero_en(en[4]),
    .pos_ref_ain_zero_en(en[3]), .neg_ref_supply_en(en[2]), .neg_ref_pin_zero_en(en[1]),
    .neg_ref_ain_one_en(en[0]), .raw_valid(raw_valid), .raw_data(raw_data),
    .cor_valid(cor_valid), .cor_data(cor_data), .offset_correction_word(ofs_w),
    .gain_correction_word(gain_w));

  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Entered just after a rising edge; request held until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [31:0] r);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx[5:0], 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      final_report();
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  function automatic logic [2:0] onehot(input logic [1:0] c);
    return (c == 2'b00) ? 3'b000 : 3'b100 >> (c - 2'b01);
  endfunction : onehot

  task automatic cor(input logic [23:0] r, input logic [23:0] e);
    raw_valid <= 1'b1;
    raw_data <= r;
    @(posedge pclk);
    raw_valid <= 1'b0;
    #1;
    chk("cor_valid", cor_valid, 1'b1);
    chk("cor_data", cor_data, e);
    @(posedge pclk);
    #1 chk("cor_pulse", cor_valid, 1'b0);
    @(posedge pclk);
  endtask : cor

  task automatic t_reset();
    logic [7:0] exp [10] = '{8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'hff, 8'h00, 8'h00};
    for (int i = 0; i < 10; i++) begin
      apb(1'b0, RSC_IDX_REF_SEL + 8'(i), 8'h00, rd);
      chk("reset_read", rd, {24'h0, exp[i]});
    end
    chk("reset_en", en, 6'b100100);
    chk("reset_gain", gain_w, 24'h400000);
    cor(24'd100, 24'd100);
  endtask : t_reset

  task automatic t_ref();
    logic [1:0] p, n;
    for (int k = 0; k < 4; k++) begin
      p = 2'(k);
      n = ~p;
      apb(1'b1, RSC_IDX_REF_SEL, {4'hf, p, n}, rd);
      apb(1'b0, RSC_IDX_REF_SEL, 8'h00, rd);
      chk("ref_read", rd, {28'h0, p, n});
      chk("pos_sel", pos_sel, p);
      chk("neg_sel", neg_sel, n);
      chk("ref_en", en, {onehot(p), onehot(n)});
    end
  endtask : t_ref

  // Offset -16 at unity gain first, then half gain; byte order shows in both words.
  task automatic t_cal();
    logic [7:0] v [6] = '{8'hf0, 8'hff, 8'hff, 8'h00, 8'h00, 8'h20};
    for (int i = 0; i < 3; i++) apb(1'b1, RSC_IDX_OFS_LOW + 8'(i), v[i], rd);
    chk("ofs_word", ofs_w, 24'hfffff0);
    cor(24'd100, 24'h000074);
    for (int i = 3; i < 6; i++) apb(1'b1, RSC_IDX_OFS_LOW + 8'(i), v[i], rd);
    chk("gain_word", gain_w, 24'h200000);
    cor(24'd100, 24'h00003a);
    cor(24'hffff9c, 24'hffffd6);
  endtask : t_cal

  task automatic t_ro();
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, RSC_IDX_SPARE_1S + 8'(i), 8'h5a, rd);
      apb(1'b0, RSC_IDX_SPARE_1S + 8'(i), 8'h00, rd);
      chk("spare_read", rd, (i == 0) ? 32'hff : 32'h0);
    end
    apb(1'b1, 8'h05, 8'h5a, rd);
    chk("unmapped_err", err, 1'b1);
    pstrb <= 4'he;
    apb(1'b1, RSC_IDX_OFS_LOW, 8'h77, rd);
    pstrb <= 4'hf;
    apb(1'b0, RSC_IDX_OFS_LOW, 8'h00, rd);
    chk("strobe_gate", rd, 32'hf0);
  endtask : t_ro

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    {presetn, psel, penable, pwrite, raw_valid} = '0;
    {paddr, pwdata, raw_data} = '0;
    pstrb = 4'hf;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    $display("test reset done");
    t_ref();
    $display("test reference done");
    t_cal();
    $display("test calibration done");
    t_ro();
    $display("test read-only done");
    final_report();
  end
endmodule : rsc_regs_tb
